// ### logic/gpiop_ports.sv
// ports 3 and 5 with their ahb-lite register slave
`timescale 1ns/1ps
module gpiop_ports (
   input wire logic hclk, // system clock
   input wire logic hresetn, // asynchronous reset
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // response
   input wire gpiop_pkg::gpiop_pmode_t power_mode, // operating mode
   input wire logic [2:0] p3_in, // port 3 pin levels
   output gpiop_pkg::gpiop_p3_pins_t p3_pins, // port 3 drive
   input wire logic [7:0] p5_in, // port 5 pin levels
   output gpiop_pkg::gpiop_p5_pins_t p5_pins, // port 5 drive
   input wire logic ser_data_out, // channel transmit bit
   input wire logic ser_clock_out, // channel clock to drive
   output logic ser_data_in, // pin 1 level to channel
   output logic ser_clock_in // pin 0 level to channel
);
   logic [7:0] p5_latch_q;
   logic [7:0] p5_dir_q;
   logic [7:0] p5_pue_q;
   logic [2:0] p3_latch_q;
   logic [2:0] p3_dir_q;
   logic [2:0] p3_pue_q;
   logic [2:0] p3_fsel_q;
   logic txd_sel_q;
   logic od_q;
   logic cks_q;
   logic [31:0] hrdata_q;
   logic wr_pend_q;
   logic [15:0] wr_idx_q;
   logic [2:0] p3_s1_q, p3_s2_q, p3_s3_q, p3_pin_q;
   logic [7:0] p5_s1_q, p5_s2_q, p5_s3_q, p5_pin_q;
   gpiop_pkg::gpiop_p3_pins_t p3_live, p3_hold_q;
   gpiop_pkg::gpiop_p5_pins_t p5_live, p5_hold_q;
   logic addr_ok, take, retain, standby;
   logic [15:0] idx;
   logic [31:0] rd_d;
   logic [2:0] p3_gen_oe;

   assign idx = haddr[17:2];
   assign addr_ok = (haddr[31:18] == 14'h0000);
   assign take = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // pin inputs: three stages, a change counts once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         p3_s1_q <= 3'h0;
         p3_s2_q <= 3'h0;
         p3_s3_q <= 3'h0;
         p3_pin_q <= 3'h0;
      end else begin
         p3_s1_q <= p3_in;
         p3_s2_q <= p3_s1_q;
         p3_s3_q <= p3_s2_q;
         p3_pin_q <= (p3_s2_q & p3_s3_q) | (p3_pin_q & (p3_s2_q ^ p3_s3_q));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         p5_s1_q <= 8'h00;
         p5_s2_q <= 8'h00;
         p5_s3_q <= 8'h00;
         p5_pin_q <= 8'h00;
      end else begin
         p5_s1_q <= p5_in;
         p5_s2_q <= p5_s1_q;
         p5_s3_q <= p5_s2_q;
         p5_pin_q <= (p5_s2_q & p5_s3_q) | (p5_pin_q & (p5_s2_q ^ p5_s3_q));
      end
   end

   // address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 16'h0000;
      end else if (hready) begin
         wr_pend_q <= take & hwrite & addr_ok;
         wr_idx_q <= idx;
      end
   end

   // port 5 registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         p5_latch_q <= gpiop_pkg::RST_ZERO;
         p5_dir_q <= gpiop_pkg::RST_ZERO;
         p5_pue_q <= gpiop_pkg::RST_ZERO;
      end else if (wr_pend_q) begin
         if (wr_idx_q == gpiop_pkg::IDX_P5_DATA) begin
            p5_latch_q <= hwdata[7:0];
         end else if (wr_idx_q == gpiop_pkg::IDX_P5_DIR) begin
            p5_dir_q <= hwdata[7:0];
         end else if (wr_idx_q == gpiop_pkg::IDX_P5_PUE) begin
            p5_pue_q <= hwdata[7:0];
         end
      end
   end

   // port 3, pin mode and channel control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         p3_latch_q <= 3'h0;
         p3_dir_q <= 3'h0;
         p3_pue_q <= 3'h0;
         p3_fsel_q <= 3'h0;
         txd_sel_q <= 1'b0;
         od_q <= 1'b0;
         cks_q <= 1'b0;
      end else if (wr_pend_q) begin
         if (wr_idx_q == gpiop_pkg::IDX_P3_DATA) begin
            p3_latch_q <= hwdata[2:0];
         end else if (wr_idx_q == gpiop_pkg::IDX_P3_DIR) begin
            p3_dir_q <= hwdata[2:0];
         end else if (wr_idx_q == gpiop_pkg::IDX_P3_PUE) begin
            p3_pue_q <= hwdata[2:0];
         end else if (wr_idx_q == gpiop_pkg::IDX_P3_FSEL) begin
            p3_fsel_q <= hwdata[2:0];
         end else if (wr_idx_q == gpiop_pkg::IDX_PIN_MODE) begin
            txd_sel_q <= hwdata[gpiop_pkg::MODE_TXD];
            od_q <= hwdata[gpiop_pkg::MODE_OD];
         end else if (wr_idx_q == gpiop_pkg::IDX_CHAN_CTRL) begin
            cks_q <= hwdata[gpiop_pkg::CHAN_CKS];
         end
      end
   end

   // read data is formed in the address phase and stands in the data phase
   always_comb begin
      rd_d = 32'h0000_0000;
      if (!addr_ok) begin
         rd_d = 32'h0000_0000;
      end else if (idx == gpiop_pkg::IDX_P5_DATA) begin
         rd_d[7:0] = (p5_dir_q & p5_latch_q) | (~p5_dir_q & p5_pin_q);
      end else if (idx == gpiop_pkg::IDX_P5_DIR) begin
         rd_d[7:0] = gpiop_pkg::WO_READ;
      end else if (idx == gpiop_pkg::IDX_P5_PUE) begin
         rd_d[7:0] = p5_pue_q;
      end else if (idx == gpiop_pkg::IDX_P3_DATA) begin
         rd_d[2:0] = (p3_dir_q & p3_latch_q) | (~p3_dir_q & p3_pin_q);
      end else if (idx == gpiop_pkg::IDX_P3_DIR) begin
         rd_d[7:0] = gpiop_pkg::WO_READ;
      end else if (idx == gpiop_pkg::IDX_P3_PUE) begin
         rd_d[2:0] = p3_pue_q;
      end else if (idx == gpiop_pkg::IDX_P3_FSEL) begin
         rd_d[2:0] = p3_fsel_q;
      end else if (idx == gpiop_pkg::IDX_PIN_MODE) begin
         rd_d[7:0] = gpiop_pkg::PIN_MODE_RSVD;
         rd_d[gpiop_pkg::MODE_TXD] = txd_sel_q;
         rd_d[gpiop_pkg::MODE_OD] = od_q;
      end else if (idx == gpiop_pkg::IDX_CHAN_CTRL) begin
         rd_d[gpiop_pkg::CHAN_CKS] = cks_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (take & ~hwrite) begin
         hrdata_q <= rd_d;
      end
   end

   // port 3 pin functions in normal operation
   always_comb begin
      p3_gen_oe = p3_dir_q;
      p3_live.out = p3_latch_q;
      if (p3_fsel_q[gpiop_pkg::FSEL_SO]) begin
         p3_gen_oe[2] = 1'b1;
         p3_live.out[2] = ser_data_out;
      end
      if (p3_fsel_q[gpiop_pkg::FSEL_SI]) begin
         p3_gen_oe[1] = 1'b0;
      end
      if (p3_fsel_q[gpiop_pkg::FSEL_SCK]) begin
         p3_gen_oe[0] = ~cks_q;
         p3_live.out[0] = ser_clock_out;
      end
      p3_live.oe = p3_gen_oe;
      if (od_q) begin
         // open drain: drive low only, high side off
         p3_live.oe[2] = p3_gen_oe[2] & ~p3_live.out[2];
         p3_live.out[2] = 1'b0;
      end
      p3_live.pu = ~p3_dir_q & p3_pue_q;
   end

   assign p5_live.out = p5_latch_q;
   assign p5_live.oe = p5_dir_q;
   assign p5_live.pu = ~p5_dir_q & p5_pue_q;

   assign retain = (power_mode == gpiop_pkg::PM_SLEEP) ||
                   (power_mode == gpiop_pkg::PM_SUBSLEEP) ||
                   (power_mode == gpiop_pkg::PM_WATCH);
   assign standby = (power_mode == gpiop_pkg::PM_STANDBY);

   // snapshot of pin drive, frozen while a retaining mode lasts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         p3_hold_q <= '0;
         p5_hold_q <= '0;
      end else if (!retain) begin
         p3_hold_q <= p3_live;
         p5_hold_q <= p5_live;
      end
   end

   always_comb begin
      if (retain) begin
         p3_pins = p3_hold_q;
         p5_pins = p5_hold_q;
      end else if (standby) begin
         p3_pins.out = 3'h0;
         p3_pins.oe = 3'h0;
         p3_pins.pu = p3_live.pu;
         p5_pins.out = 8'h00;
         p5_pins.oe = 8'h00;
         p5_pins.pu = p5_live.pu;
      end else begin
         p3_pins = p3_live;
         p5_pins = p5_live;
      end
   end

   assign ser_data_in = p3_pin_q[1];
   assign ser_clock_in = p3_pin_q[0];

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_rd(logic [15:0] i);
      take && !hwrite && addr_ok && idx == i;
   endsequence

   sequence s_wr(logic [15:0] i);
      take && hwrite && addr_ok && idx == i && hready;
   endsequence

   property p_p5_dir_ro;
      s_rd(gpiop_pkg::IDX_P5_DIR) |=> hrdata == 32'h0000_00ff;
   endproperty
   a_p5_dir_ro: assert property (p_p5_dir_ro)
      else $error("port 5 direction read not all ones");

   property p_p3_dir_ro;
      s_rd(gpiop_pkg::IDX_P3_DIR) |=> hrdata == 32'h0000_00ff;
   endproperty
   a_p3_dir_ro: assert property (p_p3_dir_ro)
      else $error("port 3 direction read not all ones");

   property p_p5_read;
      s_rd(gpiop_pkg::IDX_P5_DATA) |=> hrdata[7:0] ==
         (($past(p5_dir_q) & $past(p5_latch_q)) |
          (~$past(p5_dir_q) & $past(p5_pin_q)));
   endproperty
   a_p5_read: assert property (p_p5_read)
      else $error("port 5 data read mismatch");

   property p_p5_write;
      s_wr(gpiop_pkg::IDX_P5_DATA) ##1 1'b1 |=>
         p5_latch_q == $past(hwdata[7:0]);
   endproperty
   a_p5_write: assert property (p_p5_write)
      else $error("port 5 latch not updated by write");

   property p_p5_pullup;
      power_mode == gpiop_pkg::PM_ACTIVE |->
         p5_pins.pu == (~p5_dir_q & p5_pue_q);
   endproperty
   a_p5_pullup: assert property (p_p5_pullup)
      else $error("port 5 pull-up wrong");

   property p_p3_pullup;
      power_mode == gpiop_pkg::PM_ACTIVE |->
         p3_pins.pu == (~p3_dir_q & p3_pue_q);
   endproperty
   a_p3_pullup: assert property (p_p3_pullup)
      else $error("port 3 pull-up wrong");

   property p_so_drive;
      power_mode == gpiop_pkg::PM_ACTIVE && p3_fsel_q[2] && !od_q |->
         p3_pins.oe[2] && p3_pins.out[2] == ser_data_out;
   endproperty
   a_so_drive: assert property (p_so_drive)
      else $error("serial data out not on pin 2");

   property p_sck_in;
      power_mode == gpiop_pkg::PM_ACTIVE && p3_fsel_q[0] |->
         p3_pins.oe[0] == !cks_q;
   endproperty
   a_sck_in: assert property (p_sck_in)
      else $error("serial clock direction wrong");

   property p_hold;
      retain && $past(retain) |-> p5_pins == $past(p5_pins) &&
         p3_pins == $past(p3_pins);
   endproperty
   a_hold: assert property (p_hold)
      else $error("pins not held in retaining mode");

   property p_standby;
      standby |-> p3_pins.oe == 3'h0 && p5_pins.oe == 8'h00;
   endproperty
   a_standby: assert property (p_standby)
      else $error("pin driven in standby");
endmodule : gpiop_ports

// ### common/gpiop_pkg.sv
// package: register map, reset values and pin carriers for ports 3 and 5
//
// Overview of operation
// - select 0: pin 2 general, direction bit steers; select 1: serial data out
// - select 0: pin 1 general, direction bit steers; select 1: serial data in
// - clock select 1: pin 0 is serial clock, output if source 0, input if 1
// - port 3: off in reset, held in sleeps/watch, undriven with pull-ups kept in standby, normal active
// - port 3 pull-up on only when direction 0 and enable 1; off after reset
// - port 5 has eight pins, each driven from an 8-bit data latch
// - port 5 data read gives latch for outputs, pin level for inputs
// - port 5 direction bit 1 makes output, 0 makes input, per pin
// - port 5 direction register is write-only and reads all ones
// - port 5 pull-up on when direction 0 and enable 1, else off
// - port 5 data, direction and pull-up enable reset to zero
// - port 3 data read: latch for outputs, pin for inputs, bits 7:3 zero
// - port 3 direction 1 output, 0 input; write-only, reads all ones
// - serial-output pin is push-pull when bit 0, open-drain when bit 1
package gpiop_pkg;
   localparam int P3_WIDTH = 3;
   localparam int P5_WIDTH = 8;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_P3_DATA = 16'hffd6;
   localparam logic [15:0] IDX_P3_DIR = 16'hffe6;
   localparam logic [15:0] IDX_P3_PUE = 16'hffee;
   localparam logic [15:0] IDX_P3_FSEL = 16'hfffd;
   localparam logic [15:0] IDX_PIN_MODE = 16'hffff;
   localparam logic [15:0] IDX_P5_DATA = 16'hffd8;
   localparam logic [15:0] IDX_P5_DIR = 16'hffe8;
   localparam logic [15:0] IDX_P5_PUE = 16'hffef;
   localparam logic [15:0] IDX_CHAN_CTRL = 16'hfff0;
   // field positions
   localparam int FSEL_SO = 2;
   localparam int FSEL_SI = 1;
   localparam int FSEL_SCK = 0;
   localparam int MODE_TXD = 2;
   localparam int MODE_OD = 0;
   localparam int CHAN_CKS = 0;
   // reset values and fixed read patterns
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_PIN_MODE = 8'hf8;
   localparam logic [7:0] PIN_MODE_RSVD = 8'hf8;
   localparam logic [7:0] WO_READ = 8'hff;

   typedef enum logic [2:0] {
      PM_ACTIVE = 3'b000,
      PM_SUBACTIVE = 3'b001,
      PM_SLEEP = 3'b010,
      PM_SUBSLEEP = 3'b011,
      PM_WATCH = 3'b100,
      PM_STANDBY = 3'b101
   } gpiop_pmode_t;

   typedef struct packed {
      logic [P3_WIDTH-1:0] out;
      logic [P3_WIDTH-1:0] oe;
      logic [P3_WIDTH-1:0] pu;
   } gpiop_p3_pins_t;

   typedef struct packed {
      logic [P5_WIDTH-1:0] out;
      logic [P5_WIDTH-1:0] oe;
      logic [P5_WIDTH-1:0] pu;
   } gpiop_p5_pins_t;
endpackage : gpiop_pkg

// ### tb/gpiop_board.sv
// board model: pin levels seen by ports 3 and 5 and the serial channel
`timescale 1ns/1ps
module gpiop_board (
   input wire gpiop_pkg::gpiop_p3_pins_t p3_pins, // port 3 drive
   input wire gpiop_pkg::gpiop_p5_pins_t p5_pins, // port 5 drive
   input wire logic [2:0] ext3, // far driver on port 3
   input wire logic [7:0] ext5, // far driver on port 5
   input wire logic sdo_v, // channel bit to send
   input wire logic sck_v, // channel clock to send
   output logic [2:0] p3_in, // port 3 levels
   output logic [7:0] p5_in, // port 5 levels
   output logic ser_data_out, // channel transmit bit
   output logic ser_clock_out // channel clock
);
   // a driven pin shows its drive, a released one the far driver
   assign p3_in = (p3_pins.oe & p3_pins.out) | (~p3_pins.oe & ext3);
   assign p5_in = (p5_pins.oe & p5_pins.out) | (~p5_pins.oe & ext5);
   assign ser_data_out = sdo_v;
   assign ser_clock_out = sck_v;
endmodule : gpiop_board

// ### tb/tb_gpiop_ports.sv
// testbench for ports 3 and 5 against a register and pin model
`timescale 1ns/1ps
module tb_gpiop_ports;
   logic hclk, hresetn, hwrite, hreadyout, hresp, sdo, sck, sdi, scki;
   logic sdo_b, sck_b;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] p3_in, ext3;
   logic [7:0] p5_in, ext5, m3d, m3dir, m3pu, fsel, m7, chan;
   logic [7:0] m5d, m5dir, m5pu;
   logic [8:0] saved;
   gpiop_pkg::gpiop_pmode_t pmode;
   gpiop_pkg::gpiop_p3_pins_t p3_pins;
   gpiop_pkg::gpiop_p5_pins_t p5_pins;
   int num_errors, cmp_count, cycles;
   gpiop_ports dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .power_mode(pmode),
      .p3_in(p3_in), .p3_pins(p3_pins), .p5_in(p5_in), .p5_pins(p5_pins),
      .ser_data_out(sdo_b), .ser_clock_out(sck_b), .ser_data_in(sdi),
      .ser_clock_in(scki));
   gpiop_board board (.p3_pins(p3_pins), .p5_pins(p5_pins), .ext3(ext3),
      .ext5(ext5), .sdo_v(sdo), .sck_v(sck), .p3_in(p3_in), .p5_in(p5_in),
      .ser_data_out(sdo_b), .ser_clock_out(sck_b));
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic xfer(input logic [15:0] idx, input logic we,
         input logic [7:0] wd, output logic [31:0] rd);
      haddr <= {14'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= we;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] x;
      xfer(idx, 1'b1, d, x);
   endtask : wr
   task automatic rdchk(input string nm, input logic [15:0] idx,
         input logic [7:0] e);
      logic [31:0] x;
      xfer(idx, 1'b0, 8'h00, x);
      chk(nm, x, {24'h0, e});
      chk("hresp", 32'(hresp), 32'h0);
   endtask : rdchk
   function automatic logic [8:0] exp3();
      logic [2:0] oe, o, pu;
      oe = m3dir[2:0];
      o = m3d[2:0];
      pu = ~m3dir[2:0] & m3pu[2:0];
      if (fsel[2]) begin
         oe[2] = 1'b1;
         o[2] = sdo;
      end
      if (m7[0]) begin
         oe[2] = oe[2] & ~o[2];
         o[2] = 1'b0;
      end
      if (fsel[1]) oe[1] = 1'b0;
      if (fsel[0]) begin
         oe[0] = ~chan[0];
         o[0] = sck;
      end
      return {o & oe, oe, pu};
   endfunction : exp3
   function automatic logic [8:0] seen3();
      return {p3_pins.out & p3_pins.oe, p3_pins.oe, p3_pins.pu};
   endfunction : seen3
   // random port 3 setup through the bus, model kept alongside
   task automatic p3_cfg();
      {m3d, m3dir, m3pu} = {8'($urandom) & 8'h07, 8'($urandom) & 8'h07,
         8'($urandom) & 8'h07};
      wr(gpiop_pkg::IDX_P3_DATA, m3d);
      wr(gpiop_pkg::IDX_P3_DIR, m3dir);
      wr(gpiop_pkg::IDX_P3_PUE, m3pu);
   endtask : p3_cfg
   initial begin
      {hresetn, hwrite, sdo, sck, htrans, haddr, hwdata} = '0;
      {ext3, ext5, m5d, m5dir, m5pu, fsel, chan, m7} = '0;
      {num_errors, cmp_count, cycles} = '0;
      pmode = gpiop_pkg::PM_ACTIVE;
      saved = 9'($urandom(32'hb8ce));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("p3 pins", 32'(seen3()), 32'h0);
      chk("p5 drive", 32'({p5_pins.oe, p5_pins.pu}), 32'h0);
      rdchk("p5 dir", gpiop_pkg::IDX_P5_DIR, 8'hff);
      rdchk("p5 pue", gpiop_pkg::IDX_P5_PUE, 8'h00);
      rdchk("p3 dir", gpiop_pkg::IDX_P3_DIR, 8'hff);
      rdchk("pin mode", gpiop_pkg::IDX_PIN_MODE, 8'hf8);
      rdchk("unmapped", 16'h0100, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 20; i++) begin
         {m5d, m5dir, m5pu} = 24'($urandom);
         ext5 <= 8'($urandom);
         wr(gpiop_pkg::IDX_P5_DATA, m5d);
         wr(gpiop_pkg::IDX_P5_DIR, m5dir);
         wr(gpiop_pkg::IDX_P5_PUE, m5pu);
         @(negedge hclk);
         chk("p5 oe", 32'(p5_pins.oe), 32'(m5dir));
         chk("p5 out", 32'(p5_pins.out & m5dir), 32'(m5d & m5dir));
         chk("p5 pu", 32'(p5_pins.pu), 32'(~m5dir & m5pu));
         repeat (6) @(posedge hclk);
         rdchk("p5 data", gpiop_pkg::IDX_P5_DATA,
            (m5d & m5dir) | (ext5 & ~m5dir));
         rdchk("p5 dir", gpiop_pkg::IDX_P5_DIR, 8'hff);
         rdchk("p5 pue", gpiop_pkg::IDX_P5_PUE, m5pu);
      end
      $display("test port 5 done");
      for (int i = 0; i < 40; i++) begin
         {fsel, chan, m7} = {8'($urandom) & 8'h07, 8'($urandom) & 8'h01,
            8'($urandom) & 8'h05};
         {ext3, sdo, sck} <= 5'($urandom);
         p3_cfg();
         wr(gpiop_pkg::IDX_P3_FSEL, fsel);
         wr(gpiop_pkg::IDX_CHAN_CTRL, chan);
         wr(gpiop_pkg::IDX_PIN_MODE, m7);
         @(negedge hclk);
         chk("p3 pins", 32'(seen3()), 32'(exp3()));
         repeat (6) @(posedge hclk);
         if (fsel[1]) chk("ser in", 32'(sdi), 32'(ext3[1]));
         if (fsel[0] & chan[0]) chk("ser clk", 32'(scki), 32'(ext3[0]));
         if (fsel == 8'h00) rdchk("p3 data", gpiop_pkg::IDX_P3_DATA,
            (m3d & m3dir) | (ext3 & ~m3dir[2:0]));
         rdchk("pin mode", gpiop_pkg::IDX_PIN_MODE, 8'hf8 | m7);
      end
      $display("test port 3 done");
      for (int k = 0; k < 4; k++) begin
         saved = exp3();
         pmode <= k == 3 ? gpiop_pkg::PM_STANDBY :
            gpiop_pkg::gpiop_pmode_t'(k + 2);
         if (k == 3) saved = {6'h00, saved[2:0]};
         @(posedge hclk);
         sdo <= ~sdo;
         if (k != 3) p3_cfg();
         @(negedge hclk);
         chk("p3 held", 32'(seen3()), 32'(saved));
         @(posedge hclk);
         pmode <= gpiop_pkg::PM_SUBACTIVE;
         @(negedge hclk);
         chk("p3 normal", 32'(seen3()), 32'(exp3()));
         @(posedge hclk);
      end
      $display("test power modes done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk("p3 rst", 32'(seen3()), 32'h0);
      chk("p5 rst", 32'({p5_pins.oe, p5_pins.pu}), 32'h0);
      hresetn <= 1'b1;
      // pin synchroniser restarts from zero and needs a few edges to refill
      repeat (6) @(posedge hclk);
      rdchk("p5 data", gpiop_pkg::IDX_P5_DATA, ext5);
      rdchk("p5 pue", gpiop_pkg::IDX_P5_PUE, 8'h00);
      $display("test second reset done");
      end_of_test();
   end
endmodule : tb_gpiop_ports
